/* adc_auto_sequencer.sv */
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_auto_sequencer
   import adc_seq_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // PWM timer trigger sources, asynchronous to this clock
   input wire logic [31:0] pwm_trig_i,
   // Converter comparator bit from the SAR analog core
   input wire logic sar_cmp_i,
   // Sample-and-hold and pre-mux serial link to front end
   output logic premux_sclk_o,
   output logic premux_data_o,
   output logic premux_sh_o,
   // SAR trial code to the DAC
   output logic [11:0] sar_dac_o,
   output logic adc_pwrdn_o,
   // Four sequence request lines and manual done request
   output logic [3:0] seq_irq_o,
   output logic manual_irq_o
);
   // Control register fields
   logic [31:0] ctrl_reg;
   logic [31:0] trig_rise_reg;   // Rising edge enables
   logic [31:0] trig_fall_reg;   // Falling edge enables
   slot_cfg_s slot_cfg_mem [`NUM_SLOTS];
   logic [11:0] result_mem [`NUM_SLOTS];
   logic [23:0] slot_done_reg;   // Sticky per-slot done flags
   logic manual_done_reg;
   // Synchronised trigger pins
   logic [31:0] trig_s1_reg;
   logic [31:0] trig_s2_reg;
   logic [31:0] trig_prev_reg;
   // Engine state
   seq_state_e state_reg;
   logic [4:0] slot_reg;
   logic [4:0] cyc_reg;
   logic [2:0] div_reg;
   logic adc_tick;
   logic [11:0] sar_reg;
   logic [3:0] bit_reg;
   logic [3:0] mux_bit_reg;
   logic [7:0] mux_shift_reg;
   logic pending_reg;
   logic force_pulse;
   logic sw_mux_pulse;
   logic trig_hit;
   logic [4:0] seq_len;
   logic [4:0] conv_cycles;
   logic wr;
   logic rd;
   logic [3:0] irq_line_reg;
   logic chain_more;        // Another slot follows in this chain
   logic [4:0] next_slot;   // Slot whose channel goes out next

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign seq_len = ctrl_reg[`CTRL_LEN_LSB +: 5];
   assign chain_more = ctrl_reg[`CTRL_AUTO] && (slot_reg < seq_len);
   // Repeat restarts at slot zero, so its channel is sent then
   assign next_slot = chain_more ? 5'(slot_reg + 5'h01) : 5'h00;
   assign force_pulse = wr & (wb_adr_i == `REG_FORCE) & wb_sel_i[0] & wb_dat_i[0];
   assign sw_mux_pulse = wr & (wb_adr_i == `REG_MUXCMD) & wb_sel_i[0];
   assign conv_cycles = ctrl_reg[`CTRL_ENH] ? 5'(`CONV_ENH_CYC) : 5'(`CONV_STD_CYC);

   // Ack one cycle after request, dropped next cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
   end

   // Register writes; byte lanes honoured
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= 32'h0000_0000;
         trig_rise_reg <= 32'h0000_0000;
         trig_fall_reg <= 32'h0000_0000;
      end
      else if (wr)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_sel_i[b])
            begin
               if (wb_adr_i == `REG_CTRL)
                  ctrl_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
               if (wb_adr_i == `REG_TRIGSEL)
                  trig_rise_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
               if (wb_adr_i == `REG_SLOTCFG)
                  trig_fall_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   end

   // Slot configuration at 0x40..0x6C, no reset needed for memory
   always_ff @(posedge clk_i)
   begin
      if (wr && wb_adr_i[7:6] == 2'b01 && wb_adr_i[5:2] < 4'd12 && wb_sel_i[0])
      begin
         // Two slots per word: low byte even, second byte odd
         slot_cfg_mem[{wb_adr_i[5:2], 1'b0}] <= wb_dat_i[7:0];
         if (wb_sel_i[1])
            slot_cfg_mem[{wb_adr_i[5:2], 1'b1}] <= wb_dat_i[15:8];
      end
   end

   // Read mux; unmapped addresses read zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (rd)
      begin
         wb_dat_o <= 32'h0000_0000;
         if (wb_adr_i == `REG_CTRL)
            wb_dat_o <= ctrl_reg;
         else if (wb_adr_i == `REG_STATUS)
            wb_dat_o <= {24'h00_0000, manual_done_reg, pending_reg, slot_reg[4:0], 1'b0} |
                        {29'h0, 3'(state_reg)} << 29;
         else if (wb_adr_i == `REG_TRIGSEL)
            wb_dat_o <= trig_rise_reg;
         else if (wb_adr_i == `REG_SLOTCFG)
            wb_dat_o <= trig_fall_reg;
         else if (wb_adr_i == `REG_IRQSTAT)
            wb_dat_o <= {8'h00, slot_done_reg};
         else if (wb_adr_i[7] && wb_adr_i[6:2] < 5'd24)
            wb_dat_o <= {20'h0_0000, result_mem[wb_adr_i[6:2]]};
      end
   end

   // Two-flop synchroniser, then edge history from second stage only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trig_s1_reg <= 32'h0000_0000;
         trig_s2_reg <= 32'h0000_0000;
         trig_prev_reg <= 32'h0000_0000;
      end
      else
      begin
         trig_s1_reg <= pwm_trig_i;
         trig_s2_reg <= trig_s1_reg;
         trig_prev_reg <= trig_s2_reg;
      end
   end

   assign trig_hit = |((trig_s2_reg & ~trig_prev_reg & trig_rise_reg) |
                       (~trig_s2_reg & trig_prev_reg & trig_fall_reg));

   // Converter clock tick: 40 MHz enable from divider
   always_ff @(posedge clk_i)
   begin
      if (rst_i || div_reg == 3'(`ADCCLK_DIV - 1))
         div_reg <= 3'h0;
      else
         div_reg <= div_reg + 3'h1;
   end
   assign adc_tick = (div_reg == 3'(`ADCCLK_DIV - 1));

   // Pending start; a trigger while busy is held, not lost
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pending_reg <= 1'b0;
      else if (trig_hit || force_pulse)
         pending_reg <= ctrl_reg[`CTRL_ENABLE] & ~ctrl_reg[`CTRL_PWRDN];
      else if (state_reg == ST_IDLE && adc_tick)
         pending_reg <= 1'b0;
   end

   // Sequence engine
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_IDLE;
         slot_reg <= 5'h00;
         cyc_reg <= 5'h00;
         sar_reg <= 12'h000;
         bit_reg <= 4'h0;
      end
      else if (ctrl_reg[`CTRL_PWRDN])
         state_reg <= ST_IDLE;
      else if (adc_tick)
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               slot_reg <= 5'h00;
               if (pending_reg)
                  state_reg <= ST_MUX;
            end
            ST_MUX:
               if (mux_bit_reg == 4'h0)
               begin
                  state_reg <= ST_SAMPLE;
                  cyc_reg <= 5'h00;
               end
            ST_SAMPLE:
            begin
               cyc_reg <= cyc_reg + 5'h01;
               // sampling fills budget less 12 steps and store
               if (cyc_reg == conv_cycles - 5'd14)
               begin
                  state_reg <= ST_CONVERT;
                  sar_reg <= 12'h800;
                  bit_reg <= 4'd11;
               end
            end
            ST_CONVERT:
            begin
               if (!sar_cmp_i)
                  sar_reg[bit_reg] <= 1'b0;
               if (bit_reg != 4'h0)
                  sar_reg[bit_reg - 4'h1] <= 1'b1;
               bit_reg <= bit_reg - 4'h1;
               if (bit_reg == 4'h0)
                  state_reg <= ST_STORE;
            end
            ST_STORE:
               if (ctrl_reg[`CTRL_AUTO] && slot_reg < seq_len)
               begin
                  slot_reg <= slot_reg + 5'h01;
                  state_reg <= ST_MUX;
               end
               else if (ctrl_reg[`CTRL_REPEAT])
               begin
                  slot_reg <= 5'h00;
                  state_reg <= ST_MUX;
               end
               else
                  state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_i && adc_tick && state_reg == ST_STORE)
         result_mem[slot_reg] <= sar_reg;
   end

   // Done flags; set wins over software clear (write one to clear)
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         slot_done_reg <= 24'h00_0000;
         manual_done_reg <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < `NUM_SLOTS; i++)
            if (adc_tick && state_reg == ST_STORE && slot_reg == 5'(i))
               slot_done_reg[i] <= 1'b1;
            else if (wr && wb_adr_i == `REG_IRQSTAT && wb_dat_i[i])
               slot_done_reg[i] <= 1'b0;
         if (adc_tick && state_reg == ST_STORE && !ctrl_reg[`CTRL_AUTO])
            manual_done_reg <= 1'b1;
         else if (wr && wb_adr_i == `REG_STATUS && wb_dat_i[7])
            manual_done_reg <= 1'b0;
      end
   end

   // route enabled slot flags to lines
   always_comb
   begin
      irq_line_reg = 4'h0;
      for (int i = 0; i < `NUM_SLOTS; i++)
         if (slot_done_reg[i] && slot_cfg_mem[i].irq_en)
            irq_line_reg[slot_cfg_mem[i].irq_line] = 1'b1;
   end
   assign seq_irq_o = irq_line_reg;
   assign manual_irq_o = manual_done_reg & ctrl_reg[`CTRL_MANIRQ];

   // write-only serial link, engine or software
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mux_bit_reg <= 4'h0;
         mux_shift_reg <= 8'h00;
         premux_sclk_o <= 1'b0;
         premux_sh_o <= 1'b0;
      end
      // Falling half of a link clock: data moves only while clock is low
      else if (premux_sclk_o)
      begin
         premux_sclk_o <= 1'b0;
         mux_shift_reg <= {mux_shift_reg[6:0], 1'b0};
      end
      else if (sw_mux_pulse && mux_bit_reg == 4'h0)
      begin
         mux_shift_reg <= wb_dat_i[7:0];
         mux_bit_reg <= 4'(`MUX_FRAME_BITS);
         premux_sh_o <= wb_dat_i[8];
      end
      else if (adc_tick)
      begin
         premux_sclk_o <= 1'b0;
         // channel code covers direct and front-end inputs
         if (state_reg == ST_IDLE && pending_reg)
         begin
            mux_shift_reg <= {3'h0, slot_cfg_mem[0].channel};
            mux_bit_reg <= 4'(`MUX_FRAME_BITS);
         end
         // No frame after the last slot of a one-shot chain
         else if (state_reg == ST_STORE && (chain_more || ctrl_reg[`CTRL_REPEAT]))
         begin
            mux_shift_reg <= {3'h0, slot_cfg_mem[next_slot].channel};
            mux_bit_reg <= 4'(`MUX_FRAME_BITS);
         end
         // Rising half: current bit already stands on the data line
         else if (mux_bit_reg != 4'h0)
         begin
            premux_sclk_o <= 1'b1;
            mux_bit_reg <= mux_bit_reg - 4'h1;
         end
         // Hold asserted through sampling only
         if (state_reg == ST_SAMPLE || state_reg == ST_CONVERT)
            premux_sh_o <= (state_reg == ST_SAMPLE);
      end
   end
   assign premux_data_o = mux_shift_reg[7];
   assign sar_dac_o = sar_reg;
   assign adc_pwrdn_o = ctrl_reg[`CTRL_PWRDN];
endmodule : adc_auto_sequencer

/* adc_seq_cfg.svh */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// Register word offsets (byte address = offset)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FORCE 8'h08
`define REG_MUXCMD 8'h0C
`define REG_TRIGSEL 8'h10
`define REG_SLOTCFG 8'h14
`define REG_IRQSTAT 8'h18
`define REG_RESULT0 8'h80
// Control field positions
`define CTRL_ENABLE 0
`define CTRL_PWRDN 1
`define CTRL_REPEAT 2
`define CTRL_ENH 3
`define CTRL_MANIRQ 4
`define CTRL_AUTO 5
`define CTRL_LEN_LSB 8
// Sizes
`define NUM_SLOTS 24
`define NUM_TRIG 32
`define RES_W 12
`define CH_W 5
// Conversion timing in converter clock cycles
`define CONV_STD_CYC 16
`define CONV_ENH_CYC 20
`define ANALOG_CYC 4
// Converter clock 40 MHz from 200 MHz system clock
`define SYS_MHZ 200
`define ADCCLK_MHZ 40
`define ADCCLK_DIV (`SYS_MHZ / `ADCCLK_MHZ)
// Pre-mux link frame length in bits
`define MUX_FRAME_BITS 8
`endif

/* adc_seq_pkg.sv */
package adc_seq_pkg;
   // Sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_MUX, ST_SAMPLE, ST_CONVERT, ST_STORE} seq_state_e;
   // Per slot configuration word
   typedef struct packed {
      logic [4:0] channel;   // Input selector code
      logic irq_en;          // Interrupt at end of this slot
      logic [1:0] irq_line;  // Which of four request lines
   } slot_cfg_s;
   // Trigger selection entry
   typedef struct packed {
      logic rise;
      logic fall;
   } trig_edge_s;
endpackage : adc_seq_pkg

/* adc_seq_checker_sva.sv */
`timescale 1ns/1ps
// Bus handshake and control-word checks on the sequencer ports
module adc_seq_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [11:0] sar_dac_o,
   input wire logic adc_pwrdn_o,
   input wire logic manual_irq_o
);
   // Control word write taken on lane zero
   logic ctrl_wr;
   // Read taken inside the unmapped gap below the slot table
   logic hole_rd;
   assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && (wb_adr_i == 8'h00)
      && wb_sel_i[0];
   assign hole_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && (wb_adr_i inside {[8'h1C:8'h3C]});
   // All checks share the system clock and its reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_TAKEN:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   AST_ACK_PULSE:
   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   AST_ACK_IDLE:
   assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   AST_HOLE_ZERO:
   assert property (hole_rd |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   AST_PWRDN_SET:
   assert property (ctrl_wr && wb_dat_i[1] |-> ##[1:3] adc_pwrdn_o) else $error("no power-down");
   AST_PWRDN_CLR:
   assert property (ctrl_wr && !wb_dat_i[1] |-> ##[1:3] !adc_pwrdn_o) else $error("stuck down");
   AST_DAC_HOLD:
   assert property (adc_pwrdn_o [*4] |=> $stable(sar_dac_o)) else $error("trial code moves");
   AST_MANIRQ_MASK:
   assert property (ctrl_wr && !wb_dat_i[4] |-> ##[1:3] !manual_irq_o) else $error("irq unmasked");
endmodule : adc_seq_checker

bind adc_auto_sequencer adc_seq_checker chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sar_dac_o(sar_dac_o),
   .adc_pwrdn_o(adc_pwrdn_o), .manual_irq_o(manual_irq_o));

/* analog_front_end_model.sv */
`timescale 1ns/1ps
// Front end: shifts link frames in and compares the held level
module analog_front_end_model (
   input wire logic sclk_i,
   input wire logic data_i,
   input wire logic sh_i,
   input wire logic [11:0] dac_i,
   output logic cmp_o,
   output logic [7:0] frame_o,
   output logic [7:0] frame_count_o
);
   logic [7:0] shift_reg = 8'h00; // Bits gathered so far
   logic [2:0] bit_reg = 3'h0; // Position inside the frame
   logic [11:0] level_reg = 12'h000; // Held analog level
   initial frame_o = 8'h00;
   initial frame_count_o = 8'h00;
   always_ff @(posedge sclk_i)
   begin
      shift_reg <= {shift_reg[6:0], data_i};
      bit_reg <= bit_reg + 3'h1;
      // Eighth bit closes the frame, MSB arrived first
      if (bit_reg == 3'h7)
      begin
         frame_o <= {shift_reg[6:0], data_i};
         frame_count_o <= frame_count_o + 8'h01;
      end
   end
   // level per channel, sampled while hold is high
   always @(sh_i or frame_o)
   begin
      if (sh_i)
      begin
         level_reg = {frame_o[4:0], 7'h35};
      end
   end
   // comparator: trial at or below the level keeps the bit
   assign cmp_o = (dac_i <= level_reg);
endmodule : analog_front_end_model

/* adc_auto_sequencer_test.sv */
`timescale 1ns/1ps
// Register-level bench for the sequencer and its front end
module adc_auto_sequencer_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] pwm_trig_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, sar_cmp_i, premux_sclk_o, premux_data_o, premux_sh_o, adc_pwrdn_o, manual_irq_o;
   logic [11:0] sar_dac_o;
   logic [3:0] seq_irq_o;
   logic [7:0] frame, frame_count;
   int num_errors = 0;
   int samples_checked = 0;
   // Clock at 200 MHz
   always #2.5 clk_i = ~clk_i;
   adc_auto_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_trig_i(pwm_trig_i), .sar_cmp_i(sar_cmp_i),
      .premux_sclk_o(premux_sclk_o), .premux_data_o(premux_data_o), .premux_sh_o(premux_sh_o),
      .sar_dac_o(sar_dac_o), .adc_pwrdn_o(adc_pwrdn_o), .seq_irq_o(seq_irq_o),
      .manual_irq_o(manual_irq_o));
   analog_front_end_model afe (.sclk_i(premux_sclk_o), .data_i(premux_data_o),
      .sh_i(premux_sh_o), .dac_i(sar_dac_o), .cmp_o(sar_cmp_i), .frame_o(frame),
      .frame_count_o(frame_count));
   // Compare one value and count it
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : chk
   // One classic cycle; request held until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      xfer(1'b1, a, d, s, q);
   endtask : wr
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, 4'hF, q);
      chk(what, exp, q);
   endtask : rd
   // Bounded wait for a request line, then judge it
   task automatic wait_irq(input int n);
      int i;
      i = 0;
      while (seq_irq_o[n] !== 1'b1 && i < 3000)
      begin
         @(posedge clk_i);
         i++;
      end
      chk("seq_irq_o line", 32'h1, {31'h0, seq_irq_o[n]});
   endtask : wait_irq
   task automatic t_regs;
      rd("ctrl reset", 8'h00, 32'h0);
      wr(8'h20, 32'hFFFFFFFF, 4'hF);
      rd("unmapped", 8'h20, 32'h0);
      wr(8'h00, 32'h00000A1E, 4'hF);
      rd("ctrl", 8'h00, 32'h00000A1E);
      chk("adc_pwrdn_o", 32'h1, {31'h0, adc_pwrdn_o});
      $display("test regs done");
   endtask : t_regs
   task automatic t_mux;
      int i;
      logic [7:0] c;
      c = frame_count;
      wr(8'h0C, 32'h000001A5, 4'hF);
      for (i = 0; i < 500 && frame_count == c; i++) @(posedge clk_i);
      chk("frame", 32'hA5, {24'h0, frame});
      chk("premux_sh_o", 32'h1, {31'h0, premux_sh_o});
      $display("test mux done");
   endtask : t_mux
   task automatic t_chain;
      logic [7:0] c;
      wr(8'h40, 32'h00004818, 4'h3);
      wr(8'h44, 32'h0000008F, 4'h1);
      wr(8'h00, 32'h00000221, 4'hF);
      c = frame_count;
      wr(8'h08, 32'h1, 4'hF);
      wait_irq(3);
      chk("irq lines", 32'h8, {28'h0, seq_irq_o});
      chk("frames", 32'h3, {24'h0, frame_count - c});
      rd("result0", 8'h80, 32'h1B5);
      rd("result1", 8'h84, 32'h4B5);
      rd("result2", 8'h88, 32'h8B5);
      rd("result3", 8'h8C, 32'h0);
      wr(8'h18, 32'h7, 4'hF);
      rd("irq flags", 8'h18, 32'h0);
      $display("test chain done");
   endtask : t_chain
   task automatic t_trig;
      wr(8'h10, 32'h20, 4'hF);
      wr(8'h14, 32'h80, 4'hF);
      pwm_trig_i <= 32'hA0;
      wait_irq(3);
      wr(8'h18, 32'h4, 4'hF);
      pwm_trig_i <= 32'h20;
      wait_irq(3);
      wr(8'h18, 32'h4, 4'hF);
      $display("test trig done");
   endtask : t_trig
   task automatic t_pwrdn;
      wr(8'h00, 32'h00000223, 4'hF);
      wr(8'h08, 32'h1, 4'hF);
      repeat (400) @(posedge clk_i);
      chk("seq_irq_o quiet", 32'h0, {28'h0, seq_irq_o});
      wr(8'h00, 32'h00000221, 4'hF);
      $display("test pwrdn done");
   endtask : t_pwrdn
   // Manual single conversion in enhanced timing, interrupt enabled
   task automatic t_manual;
      int i;
      wr(8'h00, 32'h00000019, 4'hF);
      wr(8'h08, 32'h1, 4'hF);
      for (i = 0; i < 3000 && manual_irq_o !== 1'b1; i++) @(posedge clk_i);
      chk("manual_irq_o", 32'h1, {31'h0, manual_irq_o});
      rd("manual result0", 8'h80, 32'h1B5);
      wr(8'h04, 32'h80, 4'hF);
      @(posedge clk_i);
      chk("manual_irq_o clear", 32'h0, {31'h0, manual_irq_o});
      $display("test manual done");
   endtask : t_manual
   // Single closing point of the run
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Watchdog well past the expected run length
   initial
   begin
      #400000;
      num_errors++;
      summarize();
   end
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_mux();
      t_chain();
      t_trig();
      t_pwrdn();
      t_manual();
      summarize();
   end
endmodule : adc_auto_sequencer_test
